// ==== rtl/busopt_pkg.sv ====
// Purpose: Constants for the bus options register bank
// Assumes: 32-bit register port, one word per register
// Notes:   Offsets are byte addresses
package busopt_pkg;
    localparam logic [7:0]  BUSOPT_OFFSET      = 8'h20;
    localparam logic [7:0]  LINK_CTRL_OFFSET   = 8'h40;
    localparam logic [7:0]  RX_CHECK_OFFSET    = 8'h44;
    localparam int          RMC_BIT            = 31;
    localparam int          CMC_BIT            = 30;
    localparam int          ISC_BIT            = 29;
    localparam int          BMC_BIT            = 28;
    localparam int          PMC_BIT            = 27;
    localparam int          ACC_LSB            = 16;
    localparam int          REQ_LSB            = 12;
    localparam int          GEN_LSB            = 6;
    localparam int          LINK_ACTIVE_BIT    = 0;
    localparam logic [4:0]  CAP_RESET          = 5'h00;
    localparam logic [7:0]  ACC_RESET          = 8'h00;
    localparam logic [3:0]  REQ_RESET          = 4'hb;
    localparam logic [3:0]  REQ_MIN            = 4'h8;
    localparam logic [1:0]  GEN_RESET          = 2'h0;
    localparam logic [2:0]  LINK_SPEED         = 3'h3;
    localparam logic [31:0] RSVD_MASK          = 32'h07000f38;
endpackage

// ==== rtl/busopt_size_check.sv ====
// Purpose: Compares a received block write length with the request limit
// Assumes: Length in bytes, code per the request size field
// Notes:   Purely combinational
`timescale 1ns/1ns
module busopt_size_check #(
    parameter int LEN_W = 16
) (
    input  wire logic [LEN_W-1:0] i_len,
    input  wire logic [3:0]       i_code,
    output logic                  o_too_long
);
    logic [16:0] limit;
    always_comb begin
        // Five-bit shift count so code 15 gives 64 KiB instead of wrapping to 1
        limit      = 17'h00001 << ({1'b0, i_code} + 5'h01);
        o_too_long = {1'b0, i_len} > limit;
    end
endmodule

// ==== rtl/busopt_regs.sv ====
// Purpose: Bus options register with link control and size check
// Assumes: Plain register port; reset inputs asynchronous to i_clk
// Notes:   Software reset clears all fields but the request size code and the bad_cfg flag
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ns
module busopt_regs
    import busopt_pkg::*;
#(
    parameter int LEN_W = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_soft_rst,
    input  wire logic             i_bus_rst,
    input  wire logic             i_fundamental_reset_input,
    input  wire logic [7:0]       i_addr,
    input  wire logic [31:0]      i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic      [31:0]      o_rdata,
    input  wire logic             i_rx_valid,
    input  wire logic [LEN_W-1:0] i_rx_len,
    output logic                  o_ack_type_error,
    output logic                  o_link_active_control,
    output logic      [31:0]      o_bus_options
);
    typedef struct packed {
        logic [4:0]  caps;
        logic [7:0]  acc;
        logic [3:0]  req;
        logic [1:0]  gen;
        logic        link_active;
        logic [31:0] rdata;
        logic        type_err;
        logic        bad_cfg;
        logic [31:0] busopt_out;
    } busopt_state_t;

    busopt_state_t st;
    busopt_state_t next_st;
    logic          too_long;
    logic [31:0]   word;
    logic [1:0]    soft_sync;
    logic [1:0]    bus_sync;
    logic [1:0]    fundamental_reset_input_sync;

    // Reset pins come from other domains, so two flops each
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            soft_sync <= 2'h0;
            bus_sync  <= 2'h0;
            fundamental_reset_input_sync <= 2'h0;
        end else begin
            soft_sync <= {soft_sync[0], i_soft_rst};
            bus_sync  <= {bus_sync[0], i_bus_rst};
            fundamental_reset_input_sync <= {fundamental_reset_input_sync[0], i_fundamental_reset_input};
        end
    end

    busopt_size_check #(.LEN_W(LEN_W)) u_check (
        .i_len      (i_rx_len),
        .i_code     (st.req),
        .o_too_long (too_long)
    );

    always_comb begin
        word = 32'h00000000;
        word[RMC_BIT:PMC_BIT]        = st.caps;
        word[ACC_LSB+7:ACC_LSB]      = st.acc;
        word[REQ_LSB+3:REQ_LSB]      = st.req;
        word[GEN_LSB+1:GEN_LSB]      = st.gen;
        word[2:0]                    = LINK_SPEED;
        // Reserved bits stay zero from the clear above
    end

    always_comb begin
        next_st          = st;
        next_st.type_err = i_rx_valid && too_long;
        next_st.rdata    = 32'h00000000;
        if (i_rd) begin
            case (i_addr)
                BUSOPT_OFFSET:    next_st.rdata = word;
                LINK_CTRL_OFFSET: next_st.rdata = {31'h0, st.link_active};
                RX_CHECK_OFFSET:  next_st.rdata = {31'h0, st.bad_cfg};
                default:          next_st.rdata = 32'h00000000;
            endcase
        end
        if (i_wr && i_addr == BUSOPT_OFFSET) begin
            // Only writable fields are taken
            next_st.caps = i_wdata[RMC_BIT:PMC_BIT];
            next_st.acc  = i_wdata[ACC_LSB+7:ACC_LSB];
            next_st.req  = i_wdata[REQ_LSB+3:REQ_LSB];
            next_st.gen  = i_wdata[GEN_LSB+1:GEN_LSB];
        end
        if (i_wr && i_addr == LINK_CTRL_OFFSET) begin
            next_st.link_active = i_wdata[LINK_ACTIVE_BIT];
            // Flag a link enable while the size code is below 512 bytes
            next_st.bad_cfg = i_wdata[LINK_ACTIVE_BIT] && (st.req < REQ_MIN);
        end
        if (soft_sync[1]) begin
            next_st.caps        = CAP_RESET;
            next_st.acc         = ACC_RESET;
            next_st.gen         = GEN_RESET;
            next_st.link_active = 1'b0;
        end
        if (bus_sync[1] || fundamental_reset_input_sync[1]) begin
            next_st.req = REQ_RESET;
        end
        next_st.busopt_out = {next_st.caps, 3'h0, next_st.acc, next_st.req,
                              4'h0, next_st.gen, 3'h0, LINK_SPEED};
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st.caps        <= CAP_RESET;
            st.acc         <= ACC_RESET;
            st.req         <= REQ_RESET;
            st.gen         <= GEN_RESET;
            st.link_active <= 1'b0;
            st.rdata       <= 32'h00000000;
            st.type_err    <= 1'b0;
            st.bad_cfg     <= 1'b0;
            st.busopt_out  <= 32'h0000b003;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata               = st.rdata;
    assign o_ack_type_error      = st.type_err;
    assign o_link_active_control = st.link_active;
    assign o_bus_options         = st.busopt_out;

    rsvd_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_bus_options & RSVD_MASK) == 32'h0)
        else $error("reserved bits not zero");
    speed_const_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_bus_options[2:0] == 3'h3)
        else $error("link speed not 011");
    read_word_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rd && i_addr == BUSOPT_OFFSET |=> o_rdata == $past(word))
        else $error("read data wrong");
    caps_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wr && i_addr == BUSOPT_OFFSET && !soft_sync[1]
        |=> st.caps == $past(i_wdata[31:27]))
        else $error("capability write lost");
    acc_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wr && i_addr == BUSOPT_OFFSET && !soft_sync[1]
        |=> o_bus_options[23:16] == $past(i_wdata[23:16]))
        else $error("accuracy write lost");
    req_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wr && i_addr == BUSOPT_OFFSET && !bus_sync[1] && !fundamental_reset_input_sync[1]
        |=> st.req == $past(i_wdata[15:12]))
        else $error("size code write lost");
    req_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        soft_sync[1] && !bus_sync[1] && !fundamental_reset_input_sync[1] && !i_wr
        |=> st.req == $past(st.req))
        else $error("soft reset touched size code");
    req_reset_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        bus_sync[1] || fundamental_reset_input_sync[1] |=> st.req == 4'hb)
        else $error("size code not restored");
    gen_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wr && i_addr == BUSOPT_OFFSET && !soft_sync[1]
        |=> st.gen == $past(i_wdata[7:6]))
        else $error("generation write lost");
    type_err_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rx_valid && ({1'b0, i_rx_len} > (17'h1 << ({1'b0, st.req} + 5'h01)))
        |=> o_ack_type_error)
        else $error("overlong write not flagged");
endmodule

// ==== sim/busopt_regs_bench.sv ====
// Purpose: Self-checking bench for the bus options register bank
// Assumes: Design assertions run alongside; the bench drives every port itself
// Notes:   Random field values from a fixed seed, with hand-picked corner words
`timescale 1ns/1ns
module busopt_regs_bench;
    import busopt_pkg::*;
    localparam logic [31:0] RW_MASK = 32'hf8fff0c0;
    localparam logic [31:0] HW_DEF  = 32'h0000b003;
    logic        i_clk                     = 1'b0;
    logic        i_rst_n                   = 1'b0;
    logic        i_soft_rst                = 1'b0;
    logic        i_bus_rst                 = 1'b0;
    logic        i_fundamental_reset_input = 1'b0;
    logic [7:0]  i_addr                    = 8'h00;
    logic [31:0] i_wdata                   = 32'h0;
    logic        i_wr                      = 1'b0;
    logic        i_rd                      = 1'b0;
    logic        i_rx_valid                = 1'b0;
    logic [15:0] i_rx_len                  = 16'h0;
    logic [31:0] o_rdata;
    logic        o_ack_type_error;
    logic        o_link_active_control;
    logic [31:0] o_bus_options;
    int          bad_count                 = 0;
    int          comparisons               = 0;
    logic [31:0] w;
    logic [31:0] d;
    logic [16:0] lim;

    busopt_regs #(.LEN_W(16)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_soft_rst(i_soft_rst),
        .i_bus_rst(i_bus_rst), .i_fundamental_reset_input(i_fundamental_reset_input),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_rx_valid(i_rx_valid), .i_rx_len(i_rx_len), .o_ack_type_error(o_ack_type_error),
        .o_link_active_control(o_link_active_control), .o_bus_options(o_bus_options));

    initial begin
        forever #50 i_clk = ~i_clk;
    end

    // Reserved bits and link speed never follow the written value
    function automatic logic [31:0] word_exp(input logic [31:0] wv);
        return (wv & RW_MASK) | 32'h00000003;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask

    task automatic rx(input logic [15:0] len, input logic exp);
        @(posedge i_clk);
        i_rx_valid <= 1'b1;
        i_rx_len <= len;
        @(posedge i_clk);
        i_rx_valid <= 1'b0;
        #1 chk({31'h0, o_ack_type_error}, {31'h0, exp}, "length flag");
    endtask

    // Synced resets need three edges to act; hold them well past that
    task automatic sync_rst(input int k);
        @(posedge i_clk);
        i_soft_rst <= (k == 0);
        i_bus_rst <= (k == 1);
        i_fundamental_reset_input <= (k == 2);
        repeat (5) @(posedge i_clk);
        i_soft_rst <= 1'b0;
        i_bus_rst <= 1'b0;
        i_fundamental_reset_input <= 1'b0;
        repeat (5) @(posedge i_clk);
    endtask

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #500000;
        bad_count++;
        tally_and_finish;
    end

    initial begin
        void'($urandom(32'hc86f));
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(BUSOPT_OFFSET, d);
        chk(d, HW_DEF, "reset word");
        for (int n = 0; n < 24; n++) begin
            w = (n == 0) ? 32'hffffffff : (n == 1) ? 32'h0 : $urandom();
            wr(BUSOPT_OFFSET, w);
            rd(BUSOPT_OFFSET, d);
            chk(d, word_exp(w), "readback");
            chk(o_bus_options, word_exp(w), "mirror");
        end
        for (int c = 8; c < 15; c++) begin
            w = ($urandom() & 32'hffff0fff) | (32'(c) << REQ_LSB);
            wr(BUSOPT_OFFSET, w);
            lim = 17'h1 << (c + 1);
            rx(lim[15:0], 1'b0);
            rx(lim[15:0] + 16'h1, 1'b1);
        end
        wr(BUSOPT_OFFSET, 32'h0000f000);
        rx(16'hffff, 1'b0);
        wr(BUSOPT_OFFSET, 32'h8012a0c0);
        wr(LINK_CTRL_OFFSET, 32'h1);
        @(posedge i_clk);
        #1 chk({31'h0, o_link_active_control}, 32'h1, "link on");
        rd(RX_CHECK_OFFSET, d);
        chk(d, 32'h0, "config flag clear");
        wr(8'h24, 32'hffffffff);
        rd(8'h24, d);
        chk(d, 32'h0, "unmapped read");
        sync_rst(0);
        rd(BUSOPT_OFFSET, d);
        chk(d, 32'h0000a003, "soft reset");
        chk({31'h0, o_link_active_control}, 32'h0, "link after soft reset");
        wr(BUSOPT_OFFSET, 32'h00007000);
        wr(LINK_CTRL_OFFSET, 32'h1);
        rd(RX_CHECK_OFFSET, d);
        chk(d, 32'h1, "config flag set");
        for (int k = 1; k < 3; k++) begin
            wr(BUSOPT_OFFSET, 32'hffffffff);
            sync_rst(k);
            rd(BUSOPT_OFFSET, d);
            chk(d, 32'hf8ffb0c3, "size reset");
        end
        wr(BUSOPT_OFFSET, 32'hffffffff);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        @(posedge i_clk);
        #1 chk(o_bus_options, HW_DEF, "hard reset");
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(BUSOPT_OFFSET, d);
        chk(d, HW_DEF, "after hard reset");
        tally_and_finish;
    end
endmodule
